// *** design/cdc_comparator_digital_control.sv ***
`default_nettype none
module cdc_comparator_digital_control (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic rawCompare,
	input wire logic timerClockSrc,
	input wire logic portLatch,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOutEn,
	output logic analogEnable,
	output logic speedNormal,
	output logic hysteresisOn,
	output logic [1:0] posSelect,
	output logic negSelect,
	output logic gateTimerSrc,
	output logic cogShutdownSrc,
	output logic cmpIrqReq
);
	logic [7:0] ctrlZero_q, ctrlZero_d;
	logic [7:0] ctrlOne_q, ctrlOne_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] rd_q, rd_d;
	logic cmpSync1_q, cmpSync2_q, pinSync1_q, pinSync2_q;
	logic tclk1_q, tclk2_q, tclk3_q;
	logic filt_q, filt_d, res_q, res_d, syncRes_q, syncRes_d;
	logic [3:0] hold_q, hold_d;
	logic pinOut_q, pinOut_d, pinEn_q, pinEn_d;
	logic irq_q, irq_d, gate_q, gate_d;
	logic cmpOn, polInv, polarised, tclkFall, rise, fall, edgeHit, wrFlags;

	assign cmpOn = ctrlZero_q[cdc_pkg::F_ON];
	assign polInv = ctrlZero_q[cdc_pkg::F_POL];

	// two-stage synchronisers for the analog result and pin, three stages for the timer clock
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cmpSync1_q <= 1'b0;
			cmpSync2_q <= 1'b0;
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
			tclk1_q <= 1'b0;
			tclk2_q <= 1'b0;
			tclk3_q <= 1'b0;
		end else begin
			cmpSync1_q <= rawCompare;
			cmpSync2_q <= cmpSync1_q;
			pinSync1_q <= pinIn;
			pinSync2_q <= pinSync1_q;
			tclk1_q <= timerClockSrc;
			tclk2_q <= tclk1_q;
			tclk3_q <= tclk2_q;
		end
	end

	// disabled comparator reads low before polarity, so pol/on toggles show
	assign polarised = (cmpSync2_q & cmpOn) ^ polInv;
	assign tclkFall = tclk3_q & ~tclk2_q;

	always_comb begin
		filt_d = filt_q;
		hold_d = hold_q;
		if (!ctrlZero_q[cdc_pkg::F_ZLF]) begin
			filt_d = polarised;
			hold_d = 4'h0;
		end else if (hold_q != 4'h0) begin
			hold_d = hold_q - 4'h1;
		end else if (polarised != filt_q) begin
			filt_d = polarised;
			hold_d = 4'(cdc_pkg::FILT_CYC);
		end
		res_d = filt_q;
		syncRes_d = tclkFall ? filt_q : syncRes_q;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			filt_q <= 1'b0;
			hold_q <= 4'h0;
			res_q <= 1'b0;
			syncRes_q <= 1'b0;
		end else begin
			filt_q <= filt_d;
			hold_q <= hold_d;
			res_q <= res_d;
			syncRes_q <= syncRes_d;
		end
	end

	// edge detection on the registered result
	assign rise = filt_q & ~res_q;
	assign fall = ~filt_q & res_q;
	assign edgeHit = (rise & ctrlOne_q[cdc_pkg::F_INTP]) |
		(fall & ctrlOne_q[cdc_pkg::F_INTN]);
	assign wrFlags = regWrite && (regAddr == cdc_pkg::REG_FLAGS);

	always_comb begin
		ctrlZero_d = ctrlZero_q;
		ctrlOne_d = ctrlOne_q;
		flags_d = flags_q;
		if (regWrite && regAddr == cdc_pkg::REG_CTRL_ZERO)
			ctrlZero_d = (regWrData & cdc_pkg::ZERO_WMASK) |
				(ctrlZero_q & ~cdc_pkg::ZERO_WMASK);
		ctrlZero_d[cdc_pkg::F_OUT] = res_q;
		if (regWrite && regAddr == cdc_pkg::REG_CTRL_ONE)
			ctrlOne_d = regWrData;
		if (wrFlags) begin
			flags_d = (regWrData & cdc_pkg::FLAGS_WMASK) |
				(flags_q & ~cdc_pkg::FLAGS_WMASK);
			// software may only clear the flag
			if (!regWrData[cdc_pkg::F_IF])
				flags_d[cdc_pkg::F_IF] = 1'b0;
		end
		if (edgeHit)
			flags_d[cdc_pkg::F_IF] = 1'b1;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlZero_q <= cdc_pkg::CTRL_ZERO_RST;
			ctrlOne_q <= cdc_pkg::CTRL_ONE_RST;
			flags_q <= cdc_pkg::FLAGS_RST;
		end else begin
			ctrlZero_q <= ctrlZero_d;
			ctrlOne_q <= ctrlOne_d;
			flags_q <= flags_d;
		end
	end

	// read path, one cycle latency; unmapped reads return zero
	always_comb begin
		rd_d = 8'h00;
		if (regRead) begin
			unique case (regAddr)
				cdc_pkg::REG_CTRL_ZERO: rd_d = ctrlZero_q;
				cdc_pkg::REG_CTRL_ONE: rd_d = ctrlOne_q;
				cdc_pkg::REG_MIRROR: rd_d = {7'h00, res_q};
				cdc_pkg::REG_PORT: rd_d = {7'h00,
					pinSync2_q & ~flags_q[cdc_pkg::F_ANALOG_SELECT_REG]};
				cdc_pkg::REG_FLAGS: rd_d = flags_q;
				default: rd_d = 8'h00;
			endcase
		end
	end

	always_comb begin
		// sync mode chooses the timer-aligned copy for pin and timer
		gate_d = ctrlZero_q[cdc_pkg::F_SYNC] ? syncRes_q : filt_q;
		pinEn_d = ctrlZero_q[cdc_pkg::F_OE] & ~flags_q[cdc_pkg::F_PIN_DIRECTION_BIT] &
			cmpOn;
		// override of the latch does not depend on enable
		pinOut_d = ctrlZero_q[cdc_pkg::F_OE] ? gate_d : portLatch;
		irq_d = flags_q[cdc_pkg::F_IF] & flags_q[cdc_pkg::F_IE] &
			flags_q[cdc_pkg::F_PERIPHERAL_IRQ_ENABLE] & flags_q[cdc_pkg::F_GIE];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= 8'h00;
			gate_q <= 1'b0;
			pinEn_q <= 1'b0;
			pinOut_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			gate_q <= gate_d;
			pinEn_q <= pinEn_d;
			pinOut_q <= pinOut_d;
			irq_q <= irq_d;
		end
	end

	// analog controls are registered; off drops enable and hysteresis, channel selects still follow ctrlOne_q
	logic anaEn_q, anaEn_d, spd_q, spd_d;
	logic hys_q, hys_d, neg_q, neg_d;
	logic [1:0] pos_q, pos_d;

	always_comb begin
		anaEn_d = cmpOn;
		spd_d = ctrlZero_q[cdc_pkg::F_SP];
		// hysteresis bias dropped too while off, keeps current minimal
		hys_d = ctrlZero_q[cdc_pkg::F_HYS] & cmpOn;
		pos_d = ctrlOne_q[cdc_pkg::F_PCH_LO +: 2];
		neg_d = ctrlOne_q[cdc_pkg::F_NCH];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			anaEn_q <= 1'b0;
			spd_q <= 1'b1;
			hys_q <= 1'b0;
			pos_q <= 2'b00;
			neg_q <= 1'b0;
		end else begin
			anaEn_q <= anaEn_d;
			spd_q <= spd_d;
			hys_q <= hys_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	assign regRdData = rd_q;
	assign pinOut = pinOut_q;
	assign pinOutEn = pinEn_q;
	assign analogEnable = anaEn_q;
	assign speedNormal = spd_q;
	assign hysteresisOn = hys_q;
	assign posSelect = pos_q;
	assign negSelect = neg_q;
	assign gateTimerSrc = gate_q;
	assign cogShutdownSrc = gate_q;
	assign cmpIrqReq = irq_q;

	property p_flag_set;
		@(posedge clock) disable iff (sys_rst)
		edgeHit |=> flags_q[cdc_pkg::F_IF];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("edge did not set flag");

	property p_flag_sticky;
		@(posedge clock) disable iff (sys_rst)
		flags_q[cdc_pkg::F_IF] && !(wrFlags && !regWrData[cdc_pkg::F_IF])
		|=> flags_q[cdc_pkg::F_IF];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without clear");

	property p_pin_en;
		@(posedge clock) disable iff (sys_rst)
		pinOutEn |-> $past(cmpOn) && $past(ctrlZero_q[cdc_pkg::F_OE]);
	endproperty
	a_pin_en: assert property (p_pin_en)
		else $error("pin driven without enables");

	property p_irq;
		@(posedge clock) disable iff (sys_rst)
		cmpIrqReq |-> $past(flags_q[cdc_pkg::F_GIE]) &&
			$past(flags_q[cdc_pkg::F_IF]);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq without enables");

	property p_filter_hold;
		@(posedge clock) disable iff (sys_rst)
		ctrlZero_q[cdc_pkg::F_ZLF] && $changed(filt_q) && $past(hold_q) == 4'h0
		|=> $stable(filt_q) || !ctrlZero_q[cdc_pkg::F_ZLF];
	endproperty
	a_filter_hold: assert property (p_filter_hold)
		else $error("filter reversed early");

	property p_bypass;
		@(posedge clock) disable iff (sys_rst)
		!ctrlZero_q[cdc_pkg::F_ZLF] |=> filt_q == $past(polarised);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("filter not bypassed");

	property p_mirror;
		@(posedge clock) disable iff (sys_rst)
		regRead && regAddr == cdc_pkg::REG_MIRROR |=> regRdData[0] == $past(res_q);
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("mirror mismatch");

	property p_sync;
		@(posedge clock) disable iff (sys_rst)
		tclkFall |=> syncRes_q == $past(filt_q);
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync capture missed");

	property p_pin_pin_direction_bit;
		@(posedge clock) disable iff (sys_rst)
		pinOutEn |-> !$past(flags_q[cdc_pkg::F_PIN_DIRECTION_BIT]);
	endproperty
	a_pin_pin_direction_bit: assert property (p_pin_pin_direction_bit)
		else $error("pin driven while set as input");

	property p_pin_latch;
		@(posedge clock) disable iff (sys_rst)
		!ctrlZero_q[cdc_pkg::F_OE] |=> pinOut == $past(portLatch);
	endproperty
	a_pin_latch: assert property (p_pin_latch)
		else $error("pin lost port latch value");

	property p_polarity;
		@(posedge clock) disable iff (sys_rst)
		cmpOn && !ctrlZero_q[cdc_pkg::F_ZLF]
		|=> filt_q == ($past(cmpSync2_q) ^ $past(polInv));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("polarity not applied");

	property p_cout_bit;
		@(posedge clock) disable iff (sys_rst)
		regRead && regAddr == cdc_pkg::REG_CTRL_ZERO
		|=> regRdData[cdc_pkg::F_OUT] == $past(res_q, 2);
	endproperty
	a_cout_bit: assert property (p_cout_bit)
		else $error("status bit does not follow result");

	property p_flag_only_edge;
		@(posedge clock) disable iff (sys_rst)
		!flags_q[cdc_pkg::F_IF] && !edgeHit
		|=> !flags_q[cdc_pkg::F_IF];
	endproperty
	a_flag_only_edge: assert property (p_flag_only_edge)
		else $error("flag set without edge");

	property p_irq_set;
		@(posedge clock) disable iff (sys_rst)
		flags_q[cdc_pkg::F_IF] && flags_q[cdc_pkg::F_IE] &&
			flags_q[cdc_pkg::F_PERIPHERAL_IRQ_ENABLE] && flags_q[cdc_pkg::F_GIE]
		|=> cmpIrqReq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("irq missing with all enables");

	property p_inputs_off;
		@(posedge clock) disable iff (sys_rst)
		!cmpOn |=> !analogEnable && !hysteresisOn;
	endproperty
	a_inputs_off: assert property (p_inputs_off)
		else $error("inputs left connected while off");

	property p_speed;
		@(posedge clock) disable iff (sys_rst)
		speedNormal == $past(ctrlZero_q[cdc_pkg::F_SP]);
	endproperty
	a_speed: assert property (p_speed)
		else $error("speed output does not follow bit");

	property p_sync_gate;
		@(posedge clock) disable iff (sys_rst)
		ctrlZero_q[cdc_pkg::F_SYNC]
		|=> gateTimerSrc == $past(syncRes_q);
	endproperty
	a_sync_gate: assert property (p_sync_gate)
		else $error("gate source not the synced copy");

	property p_port_analog;
		@(posedge clock) disable iff (sys_rst)
		regRead && regAddr == cdc_pkg::REG_PORT &&
			flags_q[cdc_pkg::F_ANALOG_SELECT_REG]
		|=> regRdData == 8'h00;
	endproperty
	a_port_analog: assert property (p_port_analog)
		else $error("analog pin read not zero");
endmodule : cdc_comparator_digital_control
`default_nettype wire

// *** design/cdc_pkg.sv ***
`default_nettype none
package cdc_pkg;
	// register indices on the plain port (byte addresses)
	localparam logic [3:0] REG_CTRL_ZERO = 4'h0;
	localparam logic [3:0] REG_CTRL_ONE = 4'h1;
	localparam logic [3:0] REG_MIRROR = 4'h2;
	localparam logic [3:0] REG_PORT = 4'h3;
	localparam logic [3:0] REG_FLAGS = 4'h4;
	// cmp_ctrl_zero fields
	localparam int F_ON = 7;
	localparam int F_OUT = 6;
	localparam int F_OE = 5;
	localparam int F_POL = 4;
	localparam int F_ZLF = 3;
	localparam int F_SP = 2;
	localparam int F_HYS = 1;
	localparam int F_SYNC = 0;
	// cmp_ctrl_one fields
	localparam int F_INTP = 7;
	localparam int F_INTN = 6;
	localparam int F_PCH_LO = 3;
	localparam int F_NCH = 0;
	// flags register fields
	localparam int F_IF = 0;
	localparam int F_IE = 1;
	localparam int F_PIN_DIRECTION_BIT = 2;
	localparam int F_ANALOG_SELECT_REG = 3;
	localparam int F_PERIPHERAL_IRQ_ENABLE = 4;
	localparam int F_GIE = 5;
	localparam logic [7:0] CTRL_ZERO_RST = 8'h04;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h0C;
	localparam logic [7:0] FLAGS_WMASK = 8'h3E;
	localparam logic [7:0] ZERO_WMASK = 8'hBF;
	// filter hold time
	localparam int CLK_MHZ = 25;
	localparam int FILT_NS = 20;
	localparam int FILT_CYC_RAW = (FILT_NS * CLK_MHZ) / 1000;
	localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
	typedef enum logic [1:0] {
		POS_PIN = 2'b00,
		POS_DAC = 2'b01,
		POS_FVR = 2'b10,
		POS_GND = 2'b11
	} cdc_pos_t;
endpackage : cdc_pkg
`default_nettype wire

// *** verification/cdc_analog_model.sv ***
`default_nettype none
module cdc_analog_model (
	input wire logic clock,
	input wire logic analogEnable,
	input wire logic posAbove,
	input wire logic tclkRun,
	output logic rawCompare,
	output logic timerClockSrc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] divQ = 2'h0;
	logic tclkQ = 1'b1;
	logic rawQ = 1'b0;
	// inputs cut while off: level wanders, the block must gate it
	always_ff @(posedge clock) begin
		rawQ <= analogEnable ? posAbove : ~rawQ;
		// timer clock stands still unless the bench lets it run
		if (tclkRun) begin
			divQ <= divQ + 2'h1;
			if (divQ == 2'h3) begin
				tclkQ <= ~tclkQ;
			end
		end
	end
	assign rawCompare = rawQ;
	assign timerClockSrc = tclkQ;
endmodule : cdc_analog_model
`default_nettype wire

// *** verification/cdc_comparator_digital_control_tb.sv ***
`default_nettype none
module cdc_comparator_digital_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ON = 8'h01 << cdc_pkg::F_ON;
	localparam logic [7:0] OUT = 8'h01 << cdc_pkg::F_OUT;
	localparam logic [7:0] OE = 8'h01 << cdc_pkg::F_OE;
	localparam logic [7:0] POL = 8'h01 << cdc_pkg::F_POL;
	localparam logic [7:0] SP = 8'h01 << cdc_pkg::F_SP;
	localparam logic [7:0] HY = 8'h01 << cdc_pkg::F_HYS;
	localparam logic [7:0] SY = 8'h01 << cdc_pkg::F_SYNC;
	localparam logic [7:0] ZF = 8'h01 << cdc_pkg::F_ZLF;
	localparam logic [7:0] IP = 8'h01 << cdc_pkg::F_INTP;
	localparam logic [7:0] IN = 8'h01 << cdc_pkg::F_INTN;
	localparam logic [7:0] FLG = 8'h01 << cdc_pkg::F_IF;
	localparam logic [7:0] IE = 8'h01 << cdc_pkg::F_IE;
	localparam logic [7:0] TR = 8'h01 << cdc_pkg::F_PIN_DIRECTION_BIT;
	localparam logic [7:0] EN3 = IE | (8'h01 << cdc_pkg::F_PERIPHERAL_IRQ_ENABLE)
		| (8'h01 << cdc_pkg::F_GIE);
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic portLatch = 1'b1;
	logic posAbove = 1'b0;
	logic tclkRun = 1'b0;
	logic [7:0] regRdData;
	logic rawCompare, timerClockSrc, pinOut, pinOutEn, analogEnable;
	logic speedNormal, hysteresisOn, negSelect, gateTimerSrc;
	logic cogShutdownSrc, cmpIrqReq;
	logic [1:0] posSelect;
	logic [7:0] hiCount;
	wire logic pinIn = pinOutEn ? pinOut : 1'b1;
	int bad_count = 0;
	int compares = 0;
	cdc_comparator_digital_control dut (.clock(clock), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .rawCompare(rawCompare),
		.timerClockSrc(timerClockSrc), .portLatch(portLatch), .pinIn(pinIn),
		.pinOut(pinOut), .pinOutEn(pinOutEn), .analogEnable(analogEnable),
		.speedNormal(speedNormal), .hysteresisOn(hysteresisOn),
		.posSelect(posSelect), .negSelect(negSelect),
		.gateTimerSrc(gateTimerSrc), .cogShutdownSrc(cogShutdownSrc),
		.cmpIrqReq(cmpIrqReq));
	cdc_analog_model far (.clock(clock), .analogEnable(analogEnable),
		.posAbove(posAbove), .tclkRun(tclkRun), .rawCompare(rawCompare),
		.timerClockSrc(timerClockSrc));
	initial forever #20 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
	endtask : rd
	// covers synchronizer, filter and output register stages
	task automatic settle;
		repeat (8) @(posedge clock);
		#1;
	endtask : settle
	// one-cycle pulse on the analog input; counts cycles the result is high
	task automatic pulse_count(output logic [7:0] hi);
		hi = 8'h00;
		@(posedge clock);
		posAbove <= 1'b1;
		@(posedge clock);
		posAbove <= 1'b0;
		repeat (10) begin
			@(posedge clock);
			#1 hi = hi + 8'(gateTimerSrc);
		end
	endtask : pulse_count
	task automatic wrap_up;
		$display("compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		#1 chk({7'h00, speedNormal}, 8'h01);
		rd(cdc_pkg::REG_CTRL_ZERO, cdc_pkg::CTRL_ZERO_RST);
		rd(cdc_pkg::REG_FLAGS, cdc_pkg::FLAGS_RST);
		rd(4'hF, 8'h00);
		rd(cdc_pkg::REG_PORT, 8'h00);
		wr(cdc_pkg::REG_FLAGS, TR);
		settle();
		rd(cdc_pkg::REG_PORT, 8'h01);
		$display("test reset and port done");
		posAbove <= 1'b1;
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP | OUT);
		settle();
		chk({7'h00, analogEnable}, 8'h01);
		rd(cdc_pkg::REG_CTRL_ZERO, ON | SP | OUT);
		rd(cdc_pkg::REG_MIRROR, 8'h01);
		chk({7'h00, gateTimerSrc}, 8'h01);
		chk({7'h00, cogShutdownSrc}, 8'h01);
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP | POL);
		settle();
		rd(cdc_pkg::REG_MIRROR, 8'h00);
		wr(cdc_pkg::REG_CTRL_ZERO, POL);
		settle();
		chk({6'h00, analogEnable, speedNormal}, 8'h00);
		rd(cdc_pkg::REG_CTRL_ZERO, POL | OUT);
		$display("test result path done");
		for (int i = 0; i < 4; i++) begin
			wr(cdc_pkg::REG_CTRL_ONE, 8'(i << cdc_pkg::F_PCH_LO) | 8'(i & 1));
			wr(cdc_pkg::REG_CTRL_ZERO,
				ON | SP | ((i & 1) != 0 ? HY : 8'h00));
			settle();
			chk({6'h00, posSelect}, 8'(i));
			chk({7'h00, negSelect}, 8'(i & 1));
			chk({7'h00, hysteresisOn}, 8'(i & 1));
		end
		$display("test analog controls done");
		wr(cdc_pkg::REG_CTRL_ZERO, ON | OE | SP);
		wr(cdc_pkg::REG_FLAGS, 8'h00);
		settle();
		chk({6'h00, pinOutEn, pinOut}, 8'h03);
		wr(cdc_pkg::REG_CTRL_ZERO, OE | SP);
		settle();
		chk({6'h00, pinOutEn, pinOut}, 8'h00);
		wr(cdc_pkg::REG_CTRL_ZERO, SP);
		settle();
		chk({7'h00, pinOut}, 8'h01);
		@(posedge clock);
		portLatch <= 1'b0;
		settle();
		chk({7'h00, pinOut}, 8'h00);
		$display("test pin done");
		posAbove <= 1'b0;
		wr(cdc_pkg::REG_CTRL_ONE, IP);
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP);
		wr(cdc_pkg::REG_FLAGS, EN3);
		settle();
		posAbove <= 1'b1;
		settle();
		chk({7'h00, cmpIrqReq}, 8'h01);
		rd(cdc_pkg::REG_FLAGS, EN3 | FLG);
		wr(cdc_pkg::REG_FLAGS, IE | FLG);
		settle();
		chk({7'h00, cmpIrqReq}, 8'h00);
		rd(cdc_pkg::REG_FLAGS, IE | FLG);
		wr(cdc_pkg::REG_FLAGS, EN3);
		posAbove <= 1'b0;
		settle();
		rd(cdc_pkg::REG_FLAGS, EN3);
		wr(cdc_pkg::REG_CTRL_ONE, IN);
		posAbove <= 1'b1;
		settle();
		rd(cdc_pkg::REG_FLAGS, EN3);
		posAbove <= 1'b0;
		settle();
		rd(cdc_pkg::REG_FLAGS, EN3 | FLG);
		wr(cdc_pkg::REG_CTRL_ONE, IP | IN);
		wr(cdc_pkg::REG_CTRL_ZERO, SP);
		wr(cdc_pkg::REG_FLAGS, EN3);
		wr(cdc_pkg::REG_CTRL_ZERO, SP | POL);
		settle();
		rd(cdc_pkg::REG_FLAGS, EN3 | FLG);
		$display("test interrupt done");
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP | SY);
		settle();
		posAbove <= 1'b1;
		settle();
		chk({7'h00, gateTimerSrc}, 8'h00);
		tclkRun <= 1'b1;
		repeat (3) settle();
		chk({7'h00, gateTimerSrc}, 8'h01);
		$display("test sync done");
		posAbove <= 1'b0;
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP);
		settle();
		pulse_count(hiCount);
		chk(hiCount, 8'h01);
		wr(cdc_pkg::REG_CTRL_ZERO, ON | SP | ZF);
		settle();
		pulse_count(hiCount);
		chk(hiCount, 8'(1 + cdc_pkg::FILT_CYC));
		$display("test filter done");
		wrap_up();
	end
endmodule : cdc_comparator_digital_control_tb
`default_nettype wire
